// ---- dv/palette_host_access_port_test.sv ----
// Self-checking bench for the host access port.
// Assumes pha_port, pha_host and the bound checker.
module palette_host_access_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic       i_core_clk;
    logic       i_rst = 1'b1;
    logic       w8 = 1'b1;
    logic [7:0] pix = 8'h00;
    logic [3:0] ovl = 4'h0;
    wire        wr_n, rd_n, oe;
    wire  [2:0] rs;
    wire  [7:0] hd, rdd, r, g, b;
    int         n_errors = 0;
    int         checks_done = 0;
    pha_host h (.i_core_clk(i_core_clk), .i_rd_data(rdd), .i_rd_oe(oe),
        .o_wr_n(wr_n), .o_rd_n(rd_n), .o_register_select(rs), .o_data(hd));
    pha_port dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_wr_n(wr_n),
        .i_rd_n(rd_n), .i_register_select(rs), .i_data(hd), .o_data(rdd),
        .o_data_oe(oe), .i_width_8(w8), .i_pixel_index_inputs(pix),
        .i_overlay_select(ovl), .o_red(r), .o_green(g), .o_blue(b));
    initial begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic er(input logic [2:0] s, input logic [7:0] exp);
        logic [7:0] d;
        h.rd(s, d);
        chk8(d, exp);
    endtask
    task automatic wr3(input logic [2:0] s, input logic [23:0] c);
        h.wr(s, c[23:16]);
        h.wr(s, c[15:8]);
        h.wr(s, c[7:0]);
    endtask
    task automatic rd3(input logic [2:0] s, input logic [23:0] c);
        er(s, c[23:16]);
        er(s, c[15:8]);
        er(s, c[7:0]);
    endtask
    // Pixel path settles a few cycles after its inputs move
    task automatic pix3(input logic [23:0] c);
        repeat (6) @(negedge i_core_clk);
        chk8(r, c[23:16]);
        chk8(g, c[15:8]);
        chk8(b, c[7:0]);
    endtask
    task automatic close_out();
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge i_core_clk);
        i_rst = 1'b0;
        er(3'h0, 8'h00);
        er(3'h2, 8'hff);
        h.wr(3'h0, 8'hfe);
        wr3(3'h1, 24'h112233);
        wr3(3'h1, 24'h445566);
        er(3'h3, 8'h00);
        h.wr(3'h0, 8'hfe);
        h.wr(3'h1, 8'haa);
        h.wr(3'h3, 8'hfe);
        er(3'h1, 8'h11);
        er(3'h0, 8'hfe);
        er(3'h1, 8'h22);
        er(3'h1, 8'h33);
        rd3(3'h1, 24'h445566);
        er(3'h3, 8'h00);
        h.wr(3'h4, 8'h31);
        wr3(3'h5, 24'ha1a2a3);
        er(3'h7, 8'h32);
        ovl = 4'h1;
        pix3(24'ha1a2a3);
        h.wr(3'h7, 8'hf1);
        rd3(3'h5, 24'ha1a2a3);
        h.wr(3'h4, 8'h00);
        wr3(3'h5, 24'h777777);
        er(3'h7, 8'h01);
        h.wr(3'h7, 8'h10);
        rd3(3'h5, 24'h000000);
        h.wr(3'h6, 8'h55);
        er(3'h6, 8'h00);
        er(3'h7, 8'h11);
        ovl = 4'h0;
        pix = 8'hff;
        h.wr(3'h2, 8'hfe);
        er(3'h2, 8'hfe);
        pix3(24'h112233);
        w8 = 1'b0;
        h.wr(3'h0, 8'h05);
        wr3(3'h1, 24'hffc180);
        h.wr(3'h3, 8'h05);
        rd3(3'h1, 24'h3f0100);
        h.wr(3'h7, 8'h01);
        rd3(3'h5, 24'h212223);
        w8 = 1'b1;
        h.wr(3'h3, 8'h05);
        rd3(3'h1, 24'h3f0100);
        close_out();
    end
    // About 660 cycles of traffic; ten thousand is a hang
    initial begin
        repeat (10000) @(posedge i_core_clk);
        n_errors++;
        close_out();
    end
endmodule // palette_host_access_port_test

// ---- dv/pha_host.sv ----
// Host processor model: write and read cycles on the strobes.
// Assumes the core clock; acts at falling edges only.
module pha_host (
    input  wire        i_core_clk,
    input  wire  [7:0] i_rd_data,
    input  wire        i_rd_oe,
    output logic       o_wr_n = 1'b1,
    output logic       o_rd_n = 1'b1,
    output logic [2:0] o_register_select = 3'h0,
    output logic [7:0] o_data = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic gap();
        repeat (5) @(negedge i_core_clk);
    endtask
    // Data set with the select, so it is steady well before the rise
    task automatic wr(input logic [2:0] rs, input logic [7:0] d);
        @(negedge i_core_clk);
        o_register_select = rs;
        o_data = d;
        o_wr_n = 1'b0;
        gap();
        o_wr_n = 1'b1;
        gap();
        o_data = ~d;
    endtask
    task automatic rd(input logic [2:0] rs, output logic [7:0] d);
        int n;
        @(negedge i_core_clk);
        o_register_select = rs;
        o_rd_n = 1'b0;
        n = 0;
        while (i_rd_oe !== 1'b1 && n < 20) begin
            @(negedge i_core_clk);
            n++;
        end
        // Data stands one edge after the drive comes on
        @(negedge i_core_clk);
        d = i_rd_data;
        o_rd_n = 1'b1;
        gap();
    endtask
endmodule // pha_host

// ---- dv/pha_port_properties.sv ----
// Pin-level checks for the host access port.
// Assumes binding to pha_port with a slow host on the strobes.
module pha_port_props (
    input wire       i_core_clk,
    input wire       i_rst,
    input wire       i_wr_n,
    input wire       i_rd_n,
    input wire [2:0] i_register_select,
    input wire [7:0] i_data,
    input wire [7:0] o_data,
    input wire       o_data_oe,
    input wire       i_width_8,
    input wire [7:0] i_pixel_index_inputs,
    input wire [3:0] i_overlay_select,
    input wire [7:0] o_red,
    input wire [7:0] o_green,
    input wire [7:0] o_blue
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] rd_hi_cnt;
    // Saturates so long idle spans never wrap
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst || !i_rd_n)
            rd_hi_cnt <= 4'h0;
        else if (rd_hi_cnt != 4'hf)
            rd_hi_cnt <= rd_hi_cnt + 4'h1;
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    oe_rise_a: assert property ($fell(i_rd_n) |-> ##[2:5] o_data_oe)
        else $error("bus drive late");
    oe_drop_a: assert property ($rose(i_rd_n) |-> ##[2:5] !o_data_oe)
        else $error("bus drive held");
    oe_cause_a: assert property ($rose(o_data_oe) |-> !$past(i_rd_n, 2))
        else $error("bus drive without read");
    oe_quiet_a: assert property (rd_hi_cnt > 4'h5 |-> !o_data_oe)
        else $error("bus driven while idle");
    data_hold_a: assert property (rd_hi_cnt > 4'h6 |-> $stable(o_data))
        else $error("read data moved");
    six_bit_a: assert property (o_data_oe && $past(o_data_oe, 2)
        && !i_width_8 && !$past(i_width_8, 6)
        && $past(i_register_select, 4) inside {3'h1, 3'h5}
        |-> o_data[7:6] == 2'b00) else $error("high bits set");
    reserved_zero_a: assert property (o_data_oe && $past(o_data_oe, 2)
        && $past(i_register_select, 4) == 3'h6 |-> o_data == 8'h00)
        else $error("reserved read not zero");
    reset_vals_a: assert property ($fell(i_rst) |-> o_data == 8'h00
        && !o_data_oe && {o_red, o_green, o_blue} == 24'h0)
        else $error("bad reset values");
endmodule // pha_port_props
bind pha_port pha_port_props u_props (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_wr_n(i_wr_n), .i_rd_n(i_rd_n), .i_register_select(i_register_select),
    .i_data(i_data), .o_data(o_data), .o_data_oe(o_data_oe),
    .i_width_8(i_width_8), .i_pixel_index_inputs(i_pixel_index_inputs),
    .i_overlay_select(i_overlay_select), .o_red(o_red), .o_green(o_green),
    .o_blue(o_blue));

// ---- logic/pha_consts.vh ----
// Constants for the palette host access port: select codes, phases, widths.
// Assumes inclusion by the port logic only; holds definitions alone.
`ifndef PHA_CONSTS_VH
`define PHA_CONSTS_VH
`define PHA_RS_PTR_RAM_WR 3'h0
`define PHA_RS_PALETTE    3'h1
`define PHA_RS_MASK       3'h2
`define PHA_RS_PTR_RAM_RD 3'h3
`define PHA_RS_PTR_OVL_WR 3'h4
`define PHA_RS_OVERLAY    3'h5
`define PHA_RS_RESERVED   3'h6
`define PHA_RS_PTR_OVL_RD 3'h7
`define PHA_PHASE_RED     2'h0
`define PHA_PHASE_GREEN   2'h1
`define PHA_PHASE_BLUE    2'h2
`define PHA_PTR_RESET     8'h00
`define PHA_PTR_LAST      8'hff
`define PHA_MASK_RESET    8'hff
`define PHA_SIX_BIT_MASK  8'h3f
`define PHA_OVL_RESERVED  4'h0
`define PHA_SYNC_STAGES   2
`endif

// ---- logic/pha_port.v ----
// Host access port: pointer, phase counter, palette and overlay storage.
// Assumes strobes, select, data and width pins are asynchronous to the core.
`include "pha_consts.vh"
module pha_port #(
    parameter ENTRIES = 256,
    parameter OVERLAYS = 16
) (
    input  wire        i_core_clk,
    input  wire        i_rst,
    input  wire        i_wr_n,
    input  wire        i_rd_n,
    input  wire [2:0]  i_register_select,
    input  wire [7:0]  i_data,
    output reg  [7:0]  o_data,
    output wire        o_data_oe,
    input  wire        i_width_8,
    input  wire [7:0]  i_pixel_index_inputs,
    input  wire [3:0]  i_overlay_select,
    output reg  [7:0]  o_red,
    output reg  [7:0]  o_green,
    output reg  [7:0]  o_blue
);
    wire [1:0]  strobe_n;
    wire [11:0] bus_s;
    reg  [1:0]  strobe_n_d;
    reg  [2:0]  sel_wr;
    reg  [2:0]  sel_rd;
    reg  [7:0]  color_entry_pointer;
    reg  [1:0]  color_phase_counter;
    reg  [7:0]  read_mask;
    reg  [7:0]  hold_red;
    reg  [7:0]  hold_green;
    reg  [23:0] palette [0:ENTRIES-1];
    reg  [23:0] overlay [0:OVERLAYS-1];
    reg  [23:0] entry;
    reg  [7:0]  comp;
    reg  [7:0]  wdata;
    reg  [7:0]  next_data;
    reg  [7:0]  masked_index;

    wire [2:0]  sel_s;
    wire [7:0]  data_s;
    wire        width8_s;
    wire        wr_fall;
    wire        wr_rise;
    wire        rd_fall;
    wire        rd_rise;
    wire        ovl_rsv;

    // Blue-phase decode, strobe-qualified controls and the merged write triple
    wire        blue_phase;
    wire        color_wr;
    wire        color_rd;
    wire        ptr_load;
    wire        store_pal;
    wire        store_ovl;
    wire [23:0] merged;
    integer     i;

    // Strobe, select, data and width pins pass two flip-flops before any logic reads them; pixel and overlay pins do not
    pha_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_strobe_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_async    ({i_rd_n, i_wr_n}),
        .o_sync     (strobe_n)
    );
    pha_sync #(.WIDTH(12), .RESET_VAL(12'h000)) u_bus_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_async    ({i_width_8, i_register_select, i_data}),
        .o_sync     (bus_s)
    );

    assign width8_s = bus_s[11];
    assign sel_s    = bus_s[10:8];
    assign data_s   = bus_s[7:0];
    assign wr_fall  = strobe_n_d[0] & ~strobe_n[0];
    assign wr_rise  = ~strobe_n_d[0] & strobe_n[0];
    assign rd_fall  = strobe_n_d[1] & ~strobe_n[1];
    assign rd_rise  = ~strobe_n_d[1] & strobe_n[1];
    // Driver on while the synchronised read strobe is low in this and the previous sample
    assign o_data_oe = ~strobe_n[1] & ~strobe_n_d[1];
    assign ovl_rsv  = (color_entry_pointer[3:0] == `PHA_OVL_RESERVED);
    assign blue_phase = (color_phase_counter == `PHA_PHASE_BLUE);
    // Only palette and overlay selects carry color data
    assign color_wr   = wr_rise & ((sel_wr == `PHA_RS_PALETTE) |
                                   (sel_wr == `PHA_RS_OVERLAY));
    assign color_rd   = rd_rise & ((sel_rd == `PHA_RS_PALETTE) |
                                   (sel_rd == `PHA_RS_OVERLAY));
    // Any of the four pointer codes loads the pointer
    assign ptr_load   = wr_rise & ((sel_wr == `PHA_RS_PTR_RAM_WR) |
                                   (sel_wr == `PHA_RS_PTR_RAM_RD) |
                                   (sel_wr == `PHA_RS_PTR_OVL_WR) |
                                   (sel_wr == `PHA_RS_PTR_OVL_RD));
    assign store_pal  = color_wr & blue_phase &
                        (sel_wr == `PHA_RS_PALETTE);
    // Blue on the reserved slot still counts; only the store is dropped
    assign store_ovl  = color_wr & blue_phase & ~ovl_rsv &
                        (sel_wr == `PHA_RS_OVERLAY);
    assign merged     = {hold_red, hold_green, wdata};

    // Read side: entry at pointer, component by phase, width formatting
    always @* begin
        entry = overlay[color_entry_pointer[3:0]];
        if (sel_rd == `PHA_RS_PALETTE)
            entry = palette[color_entry_pointer];
        case (color_phase_counter)
            `PHA_PHASE_RED:   comp = entry[23:16];
            `PHA_PHASE_GREEN: comp = entry[15:8];
            default:          comp = entry[7:0];
        endcase
        if (!width8_s)
            comp = comp & `PHA_SIX_BIT_MASK;
        // Every pointer code reads back the pointer, mode untouched
        case (sel_rd)
            `PHA_RS_PTR_RAM_WR, `PHA_RS_PTR_RAM_RD,
            `PHA_RS_PTR_OVL_WR, `PHA_RS_PTR_OVL_RD:
                next_data = color_entry_pointer;
            `PHA_RS_MASK:     next_data = read_mask;
            `PHA_RS_PALETTE:  next_data = comp;
            `PHA_RS_OVERLAY:  next_data = ovl_rsv ? 8'h00 : comp;
            default:          next_data = 8'h00;
        endcase
        // Six-bit form drops the top two lines on color writes
        wdata = width8_s ? data_s : (data_s & `PHA_SIX_BIT_MASK);
        masked_index = read_mask & i_pixel_index_inputs;
    end

    // Strobe history and select capture
    // Edge detectors idle high so reset release makes no false edge
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            strobe_n_d <= 2'h3;
            sel_wr     <= `PHA_RS_RESERVED;
            sel_rd     <= `PHA_RS_RESERVED;
        end else begin
            strobe_n_d <= strobe_n;
            if (wr_fall)
                sel_wr <= sel_s;
            if (rd_fall)
                sel_rd <= sel_s;
        end
    end

    // Data sampled while the strobe is still low, before rise;
    // the last value then stands until the next read
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst)
            o_data <= 8'h00;
        else if (~strobe_n[1])
            o_data <= next_data;
    end

    // Pointer and hidden phase; a pointer load wins over a color strobe
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            color_entry_pointer <= `PHA_PTR_RESET;
            color_phase_counter <= `PHA_PHASE_RED;
        end else if (ptr_load) begin
            color_entry_pointer <= data_s;
            color_phase_counter <= `PHA_PHASE_RED;
        end else if (color_wr || color_rd) begin
            if (blue_phase) begin
                // 8-bit add wraps FFH to 00H
                color_entry_pointer <=
                    color_entry_pointer + 8'h01;
                color_phase_counter <= `PHA_PHASE_RED;
            end else begin
                color_phase_counter <= color_phase_counter + 2'h1;
            end
        end
    end

    // Holding bytes wait for blue; the mask loads directly
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            read_mask  <= `PHA_MASK_RESET;
            hold_red   <= 8'h00;
            hold_green <= 8'h00;
        end else begin
            if (wr_rise && sel_wr == `PHA_RS_MASK)
                read_mask <= data_s;
            if (color_wr && color_phase_counter == `PHA_PHASE_RED)
                hold_red <= wdata;
            if (color_wr && color_phase_counter == `PHA_PHASE_GREEN)
                hold_green <= wdata;
        end
    end

    // One-cycle store of the merged triple
    // Holding bytes come from earlier edges, so blue lands whole
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            for (i = 0; i < ENTRIES; i = i + 1)
                palette[i] <= 24'h000000;
            for (i = 0; i < OVERLAYS; i = i + 1)
                overlay[i] <= 24'h000000;
        end else begin
            if (store_pal)
                palette[color_entry_pointer] <= merged;
            if (store_ovl)
                overlay[color_entry_pointer[3:0]] <= merged;
        end
    end

    // Color holding registers; overlay select nonzero wins
    // One cycle behind the pixel inputs; host traffic never stalls it
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_red   <= 8'h00;
            o_green <= 8'h00;
            o_blue  <= 8'h00;
        end else if (i_overlay_select != `PHA_OVL_RESERVED) begin
            o_red   <= overlay[i_overlay_select][23:16];
            o_green <= overlay[i_overlay_select][15:8];
            o_blue  <= overlay[i_overlay_select][7:0];
        end else begin
            o_red   <= palette[masked_index][23:16];
            o_green <= palette[masked_index][15:8];
            o_blue  <= palette[masked_index][7:0];
        end
    end
endmodule // pha_port

// ---- logic/pha_sync.v ----
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes the pins change slowly against the core clock.
module pha_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input  wire             i_core_clk,
    input  wire             i_rst,
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;

    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
        end else begin
            stage1 <= i_async;
            stage2 <= stage1;
        end
    end

    assign o_sync = stage2;
endmodule // pha_sync
